// ### src/dcf_fifo.sv
/*
  Clocked 16-bit FIFO with write and read ports driven by external strobe clocks.
  Assumes i_clock is much faster than either port clock (port clocks are sampled);
  the tri-state read bus is resolved outside from o_read_data_oe.
*/
`timescale 1ns/1ns

// Summary of operation
// [RL1] The array holds a parameterisable number of sixteen-bit words, from 256 to 4096; here DCF_DEPTH fixes it at 4096.
// [RL2] Write data in and read data out are each sixteen bits wide.
// [RL3] The producer supplies a free-running write clock and all write activity follows it.
// [RL4] On a write clock rise with write enable low and not full, the word is stored and the pointer advances.
// [RL5] With write enable high a write clock rise changes neither storage nor the write pointer.
// [RL6] While the full flag is low a write attempt stores nothing and moves nothing.
// [RL7] On a read clock rise with read enable low and not empty, the oldest word goes to the output register.
// [RL8] With read enable high the output register holds and the read pointer stays.
// [RL9] While the empty flag is low a read attempt changes neither output register nor read pointer.
// [RL10] Reset low returns both pointers to the first location, full flag high and empty flag low.
// [RL11] The controlling logic resets the device after power-up before its first write.
// [RL12] The half-full flag is low while more than half the depth is stored, high otherwise.
// [RL13] The read data bus is driven while output enable is low and released while it is high.
// [RL14] The block works with both port clocks tied together or fully asynchronous.
// [RL15] Empty is judged on the read side and full on the write side, pointers crossing in gray code.
// [RL16] Full goes low when the stored count equals depth and releases once a read frees a location.
// [RL17] Empty releases only after a written word is visible to the read side and asserts after the last read.
module dcf_fifo (
  // Core clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // Write port pins
  input  wire logic                          i_write_clock,
  input  wire logic                          i_write_en_n,
  input  wire logic [dcf_pkg::DCF_DATA_W-1:0] i_write_data,
  // Read port pins
  input  wire logic                          i_read_clock,
  input  wire logic                          i_read_en_n,
  input  wire logic                          i_out_en_n,
  // Read data bus, three signals per pin minus input
  output logic      [dcf_pkg::DCF_DATA_W-1:0] o_read_data,
  output logic                               o_read_data_oe,
  // Flags
  output logic                               o_empty_flag_n,
  output logic                               o_full_flag_n,
  output logic                               o_half_full_flag_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  dcf_pkg::dcf_pins_t pins_meta_reg;
  dcf_pkg::dcf_pins_t pins_sync_reg;
  logic               write_clock_prev_reg;
  logic               read_clock_prev_reg;

  // [RL14] two-stage pin sync
  // Both port clocks are sampled, so tied or unrelated clocks behave alike
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_meta_reg <= dcf_pkg::DCF_PINS_RST;
      pins_sync_reg <= dcf_pkg::DCF_PINS_RST;
    end else begin
      pins_meta_reg <= '{write_clock: i_write_clock, write_en_n: i_write_en_n,
                         write_word: '{data: i_write_data}, read_clock: i_read_clock,
                         read_en_n: i_read_en_n, out_en_n: i_out_en_n};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // Edge history of the port clocks
  // Seeded high with the sync stage: only a real low-to-high after reset counts
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_clock_prev_reg <= 1'b1;
      read_clock_prev_reg  <= 1'b1;
    end else begin
      write_clock_prev_reg <= pins_sync_reg.write_clock;
      read_clock_prev_reg  <= pins_sync_reg.read_clock;
    end
  end

  logic write_rise;
  logic read_rise;
  // [RL3] write activity on write clock rise
  assign write_rise = pins_sync_reg.write_clock & ~write_clock_prev_reg;
  assign read_rise  = pins_sync_reg.read_clock & ~read_clock_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Write side: accept, staging buffer, array write

  logic [dcf_pkg::DCF_PTR_W-1:0]  accept_ptr_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  accept_ptr_next;
  logic [dcf_pkg::DCF_PTR_W-1:0]  array_wptr_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  array_wptr_gray_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  rptr_gray_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  rptr_gray_meta_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  rptr_gray_sync_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  rptr_seen;
  logic [dcf_pkg::DCF_PTR_W-1:0]  write_count_next;
  logic                          full_flag_n_reg;
  logic                          half_full_flag_n_reg;
  logic                          write_accept;

  dcf_pkg::dcf_word_t buf_word_reg [dcf_pkg::DCF_BUF_DEPTH];
  logic       buf_head_reg;
  logic       buf_tail_reg;
  logic [1:0] buf_count_reg;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_out_ready;
  logic       buf_push;
  logic       buf_pop;

  dcf_pkg::dcf_word_t mem_reg [dcf_pkg::DCF_DEPTH];

  assign rptr_seen = dcf_pkg::gray2bin(rptr_gray_sync_reg);

  // [RL4] accept on enabled edge
  // [RL5] enable high blocks the write
  // [RL6] full flag low refuses the write
  assign write_accept = write_rise & ~pins_sync_reg.write_en_n & full_flag_n_reg & buf_in_ready;

  // Buffer handshake; drain stalls only if the array has no free slot
  assign buf_in_ready  = (buf_count_reg != dcf_pkg::DCF_BUF_CNT_FULL);
  assign buf_out_valid = (buf_count_reg != 2'h0);
  assign buf_out_ready = ((array_wptr_reg - rptr_seen) != dcf_pkg::DCF_DEPTH_CNT);
  assign buf_push      = write_accept;
  assign buf_pop       = buf_out_valid & buf_out_ready;

  // Two-entry staging buffer
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_head_reg  <= 1'b0;
      buf_tail_reg  <= 1'b0;
      buf_count_reg <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_tail_reg <= ~buf_tail_reg;
      end
      if (buf_pop) begin
        buf_head_reg <= ~buf_head_reg;
      end
      if (buf_push && !buf_pop) begin
        buf_count_reg <= buf_count_reg + dcf_pkg::DCF_BUF_CNT_ONE;
      end else if (buf_pop && !buf_push) begin
        buf_count_reg <= buf_count_reg - dcf_pkg::DCF_BUF_CNT_ONE;
      end
    end
  end

  // Buffer storage; data needs no reset
  always_ff @(posedge i_clock) begin
    if (buf_push) begin
      buf_word_reg[buf_tail_reg] <= pins_sync_reg.write_word;
    end
  end

  // [RL1] array as indexed flops
  always_ff @(posedge i_clock) begin
    if (buf_pop) begin
      mem_reg[array_wptr_reg[dcf_pkg::DCF_ADDR_W-1:0]] <= buf_word_reg[buf_head_reg];
    end
  end

  // [RL10] pointers cleared on reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      accept_ptr_reg      <= dcf_pkg::DCF_PTR_RST;
      array_wptr_reg      <= dcf_pkg::DCF_PTR_RST;
      array_wptr_gray_reg <= dcf_pkg::DCF_PTR_RST;
    end else begin
      accept_ptr_reg <= accept_ptr_next;
      if (buf_pop) begin
        array_wptr_reg      <= array_wptr_reg + dcf_pkg::DCF_PTR_ONE;
        array_wptr_gray_reg <= dcf_pkg::bin2gray(array_wptr_reg + dcf_pkg::DCF_PTR_ONE);
      end
    end
  end

  assign accept_ptr_next  = write_accept ? accept_ptr_reg + dcf_pkg::DCF_PTR_ONE : accept_ptr_reg;
  assign write_count_next = accept_ptr_next - rptr_seen;

  // [RL15] read pointer into write side
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rptr_gray_meta_reg <= dcf_pkg::DCF_PTR_RST;
      rptr_gray_sync_reg <= dcf_pkg::DCF_PTR_RST;
    end else begin
      rptr_gray_meta_reg <= rptr_gray_reg;
      rptr_gray_sync_reg <= rptr_gray_meta_reg;
    end
  end

  // [RL16] full at depth, release after read
  // [RL12] half-full beyond half depth
  // Counting accepted words keeps buffered ones from overfilling the array
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      full_flag_n_reg      <= 1'b1;
      half_full_flag_n_reg <= 1'b1;
    end else begin
      full_flag_n_reg      <= (write_count_next != dcf_pkg::DCF_DEPTH_CNT);
      half_full_flag_n_reg <= ~(write_count_next > dcf_pkg::DCF_HALF_CNT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read side

  logic [dcf_pkg::DCF_PTR_W-1:0]  rptr_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  rptr_next;
  logic [dcf_pkg::DCF_PTR_W-1:0]  wptr_gray_meta_reg;
  logic [dcf_pkg::DCF_PTR_W-1:0]  wptr_gray_sync_reg;
  logic                          empty_flag_n_reg;
  logic                          read_take;
  dcf_pkg::dcf_word_t            read_word_reg;
  logic                          read_oe_reg;

  // [RL7] read on enabled edge
  // [RL8] enable high holds output
  // [RL9] empty flag low refuses the read
  assign read_take = read_rise & ~pins_sync_reg.read_en_n & empty_flag_n_reg;
  assign rptr_next = read_take ? rptr_reg + dcf_pkg::DCF_PTR_ONE : rptr_reg;

  // [RL15] write pointer into read side
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_gray_meta_reg <= dcf_pkg::DCF_PTR_RST;
      wptr_gray_sync_reg <= dcf_pkg::DCF_PTR_RST;
    end else begin
      wptr_gray_meta_reg <= array_wptr_gray_reg;
      wptr_gray_sync_reg <= wptr_gray_meta_reg;
    end
  end

  // [RL10] read pointer cleared on reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rptr_reg      <= dcf_pkg::DCF_PTR_RST;
      rptr_gray_reg <= dcf_pkg::DCF_PTR_RST;
    end else begin
      rptr_reg      <= rptr_next;
      rptr_gray_reg <= dcf_pkg::bin2gray(rptr_next);
    end
  end

  // [RL17] empty only from synced pointer
  // [RL10] empty low during reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      empty_flag_n_reg <= 1'b0;
    end else begin
      empty_flag_n_reg <= (dcf_pkg::gray2bin(wptr_gray_sync_reg) != rptr_next);
    end
  end

  // [RL7] output register load
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_word_reg <= '{data: dcf_pkg::DCF_DATA_RST};
    end else if (read_take) begin
      read_word_reg <= mem_reg[rptr_reg[dcf_pkg::DCF_ADDR_W-1:0]];
    end
  end

  // [RL13] drive bus while enable low
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_oe_reg <= 1'b0;
    end else begin
      read_oe_reg <= ~pins_sync_reg.out_en_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop

  assign o_read_data        = read_word_reg.data;
  assign o_read_data_oe     = read_oe_reg;
  assign o_empty_flag_n     = empty_flag_n_reg;
  assign o_full_flag_n      = full_flag_n_reg;
  assign o_half_full_flag_n = half_full_flag_n_reg;

endmodule

// ### src/dcf_pkg.sv
/*
  Constants, carrier types and gray-code helpers for the 16-bit FIFO.
  Assumes one core clock; every pin is sampled into that clock.
*/
package dcf_pkg;
  // Storage shape: 2**DCF_ADDR_W words of DCF_DATA_W bits
  localparam int unsigned DCF_DATA_W    = 16;
  localparam int unsigned DCF_ADDR_W    = 12;
  localparam int unsigned DCF_PTR_W     = DCF_ADDR_W + 1;
  localparam int unsigned DCF_DEPTH     = 4096;
  localparam int unsigned DCF_BUF_DEPTH = 2;

  // Counts and constants at pointer, data and buffer-count widths
  localparam logic [DCF_PTR_W-1:0] DCF_DEPTH_CNT = 13'h1000;
  localparam logic [DCF_PTR_W-1:0] DCF_HALF_CNT  = 13'h0800;
  localparam logic [DCF_PTR_W-1:0] DCF_PTR_ONE   = 13'h0001;
  localparam logic [DCF_PTR_W-1:0] DCF_PTR_RST   = 13'h0000;
  localparam logic [DCF_DATA_W-1:0] DCF_DATA_RST = 16'h0000;
  localparam logic [1:0] DCF_BUF_CNT_FULL        = 2'h2;
  localparam logic [1:0] DCF_BUF_CNT_ONE         = 2'h1;

  // One stored word
  typedef struct packed {
    logic [DCF_DATA_W-1:0] data;
  } dcf_word_t;

  // All pins as sampled together
  typedef struct packed {
    logic      write_clock;
    logic      write_en_n;
    dcf_word_t write_word;
    logic      read_clock;
    logic      read_en_n;
    logic      out_en_n;
  } dcf_pins_t;

  // Port clocks seeded high, so a clock already high at release shows no false rise
  localparam dcf_pins_t DCF_PINS_RST = '{write_clock: 1'b1, write_en_n: 1'b1,
    write_word: '{data: 16'h0000}, read_clock: 1'b1, read_en_n: 1'b1, out_en_n: 1'b1};

  function automatic logic [DCF_PTR_W-1:0] bin2gray(input logic [DCF_PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [DCF_PTR_W-1:0] gray2bin(input logic [DCF_PTR_W-1:0] g);
    logic [DCF_PTR_W-1:0] b;
    b = g;
    for (int i = DCF_PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction
endpackage

// ### testbench/dcf_fifo_bench.sv
/* Self-checking bench for dcf_fifo: order, flags, refusals, output enable.
   Assumes dcf_port_model supplies both port clocks at 125 ns. */
`timescale 1ns/1ns
module dcf_fifo_bench;
  logic                          i_clock, i_rst_n, i_write_en_n, i_read_en_n, i_out_en_n;
  logic [dcf_pkg::DCF_DATA_W-1:0] i_write_data, o_read_data;
  logic                          o_read_data_oe, o_empty_flag_n, o_full_flag_n, o_half_full_flag_n;
  wire logic                     wclk, rclk;
  wire logic [dcf_pkg::DCF_DATA_W-1:0] read_bus;
  int                            num_errors, checks;
  logic                          tied;
  // Bus resolved here; design only gives the enable
  assign read_bus = o_read_data_oe ? o_read_data : 16'hzzzz;
  // Core clock, 8 ns period
  always #4 i_clock = ~i_clock;
  dcf_fifo DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_write_clock(wclk), .i_write_en_n(i_write_en_n),
    .i_write_data(i_write_data), .i_read_clock(rclk), .i_read_en_n(i_read_en_n), .i_out_en_n(i_out_en_n),
    .o_read_data(o_read_data), .o_read_data_oe(o_read_data_oe), .o_empty_flag_n(o_empty_flag_n),
    .o_full_flag_n(o_full_flag_n), .o_half_full_flag_n(o_half_full_flag_n));
  dcf_port_model u_model (.i_tied(tied), .o_write_clock(wclk), .o_read_clock(rclk));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic chk_flags(input logic e, input logic f, input logic h);
    settle(12);
    check(o_empty_flag_n, e);
    check(o_full_flag_n, f);
    check(o_half_full_flag_n, h);
  endtask
  // Enable held over n rises; data moves after each fall
  task automatic wr_burst(input int n, input logic [15:0] base, input logic en);
    for (int i = 0; i < n; i++) begin
      @(negedge wclk);
      @(posedge i_clock);
      i_write_en_n <= ~en;
      i_write_data <= base + i[15:0];
      @(posedge wclk);
    end
    @(negedge wclk);
    @(posedge i_clock);
    i_write_en_n <= 1'b1;
    i_write_data <= ~i_write_data;
  endtask
  task automatic rd_burst(input int n, input logic [15:0] exp, input logic en, input logic inc);
    for (int i = 0; i < n; i++) begin
      @(negedge rclk);
      @(posedge i_clock);
      i_read_en_n <= ~en;
      @(posedge rclk);
      settle(5);
      check(o_read_data, inc ? exp + i[15:0] : exp);
    end
    @(negedge rclk);
    @(posedge i_clock);
    i_read_en_n <= 1'b1;
  endtask
  task automatic do_reset;
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    settle(3);
    i_rst_n <= 1'b1;
    settle(4);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    do_reset();
    chk_flags(1'b0, 1'b1, 1'b1);
    check(read_bus, 16'hzzzz);
  endtask
  task automatic t_order;
    @(posedge i_clock);
    i_out_en_n <= 1'b0;
    wr_burst(3, 16'h1230, 1'b1);
    wr_burst(1, 16'hdead, 1'b0);
    chk_flags(1'b1, 1'b1, 1'b1);
    rd_burst(3, 16'h1230, 1'b1, 1'b1);
    chk_flags(1'b0, 1'b1, 1'b1);
    rd_burst(1, 16'h1232, 1'b1, 1'b0);
    check(read_bus, 16'h1232);
    wr_burst(1, 16'h0bee, 1'b1);
    settle(12);
    rd_burst(1, 16'h1232, 1'b0, 1'b0);
    rd_burst(1, 16'h0bee, 1'b1, 1'b0);
    @(posedge i_clock);
    i_out_en_n <= 1'b1;
    settle(6);
    check(read_bus, 16'hzzzz);
  endtask
  // Read clock tied to the write clock for the rest of the run
  task automatic t_tied;
    @(posedge i_clock);
    tied <= 1'b1;
    settle(4);
    wr_burst(2, 16'h5a50, 1'b1);
    chk_flags(1'b1, 1'b1, 1'b1);
    rd_burst(2, 16'h5a50, 1'b1, 1'b1);
    chk_flags(1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_fill;
    wr_burst(2048, 16'h4000, 1'b1);
    chk_flags(1'b1, 1'b1, 1'b1);
    wr_burst(1, 16'h4800, 1'b1);
    chk_flags(1'b1, 1'b1, 1'b0);
    wr_burst(2047, 16'h4801, 1'b1);
    chk_flags(1'b1, 1'b0, 1'b0);
    wr_burst(1, 16'hffff, 1'b1);
    chk_flags(1'b1, 1'b0, 1'b0);
    rd_burst(1, 16'h4000, 1'b1, 1'b0);
    chk_flags(1'b1, 1'b1, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Cut a hang short: fill is about 512 us, the rest a few us; stays under 100k cycles
  initial begin
    #700000;
    num_errors++;
    conclude();
  end
  // Main sequence, second reset at the end
  initial begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    i_write_en_n = 1'b1;
    i_read_en_n = 1'b1;
    i_out_en_n = 1'b1;
    i_write_data = 16'h0000;
    tied = 1'b0;
    t_reset();
    t_order();
    t_tied();
    t_fill();
    t_reset();
    conclude();
  end
endmodule

// ### testbench/dcf_fifo_chk.sv
/* Port checker for dcf_fifo, bound after the module.
   Assumes enables stay steady from before a port clock rise until its fall. */
`timescale 1ns/1ns
module dcf_fifo_chk (
  // Core clock and reset
  input wire logic                          i_clock,
  input wire logic                          i_rst_n,
  // Port pins
  input wire logic                          i_write_clock,
  input wire logic                          i_write_en_n,
  input wire logic [dcf_pkg::DCF_DATA_W-1:0] i_write_data,
  input wire logic                          i_read_clock,
  input wire logic                          i_read_en_n,
  input wire logic                          i_out_en_n,
  // Design outputs
  input wire logic [dcf_pkg::DCF_DATA_W-1:0] o_read_data,
  input wire logic                          o_read_data_oe,
  input wire logic                          o_empty_flag_n,
  input wire logic                          o_full_flag_n,
  input wire logic                          o_half_full_flag_n
);
  logic [2:0] up_cnt_reg;
  // Settle count, keeps history checks off reset-time values
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Enabled port clock rises
  sequence s_write_rise;
    !i_write_en_n && !i_write_clock ##1 !i_write_en_n && i_write_clock;
  endsequence
  sequence s_read_rise;
    !i_read_en_n && !i_read_clock ##1 !i_read_en_n && i_read_clock;
  endsequence
  a_reset_state: assert property ($rose(i_rst_n) |->
    !o_empty_flag_n && o_full_flag_n && o_half_full_flag_n && !o_read_data_oe) else $error("bad reset state");
  a_oe_delay: assert property (up_cnt_reg == 3'h7 |->
    o_read_data_oe == !$past(i_out_en_n, 3)) else $error("output enable lag wrong");
  a_flag_excl: assert property (!(!o_full_flag_n && !o_empty_flag_n)) else $error("full and empty");
  a_full_half: assert property (!o_full_flag_n |-> !o_half_full_flag_n) else $error("full not half");
  a_empty_half: assert property (!o_empty_flag_n |-> o_half_full_flag_n) else $error("empty half");
  a_data_cause: assert property (up_cnt_reg == 3'h7 && $changed(o_read_data) |-> $past(o_empty_flag_n) &&
    (!$past(i_read_en_n, 2) || !$past(i_read_en_n, 3) || !$past(i_read_en_n, 4))) else $error("stray read");
  a_full_release: assert property (s_read_rise ##0 !o_full_flag_n |-> ##[1:16] o_full_flag_n)
    else $error("full not released");
  a_empty_release: assert property (s_write_rise ##0 !o_empty_flag_n |-> ##[1:16] o_empty_flag_n)
    else $error("empty not released");
endmodule
bind dcf_fifo dcf_fifo_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_write_clock(i_write_clock),
  .i_write_en_n(i_write_en_n), .i_write_data(i_write_data), .i_read_clock(i_read_clock),
  .i_read_en_n(i_read_en_n), .i_out_en_n(i_out_en_n), .o_read_data(o_read_data),
  .o_read_data_oe(o_read_data_oe), .o_empty_flag_n(o_empty_flag_n), .o_full_flag_n(o_full_flag_n),
  .o_half_full_flag_n(o_half_full_flag_n));

// ### testbench/dcf_port_model.sv
/* Far-side port clocks: producer write clock and consumer read clock.
   Assumes the bench drives enables and data against these clocks. */
`timescale 1ns/1ns
module dcf_port_model (
  // Mode select: read clock tied to write clock
  input  wire logic i_tied,
  // Port clocks
  output logic      o_write_clock,
  output logic      o_read_clock
);
  logic read_clock_free;
  initial begin
    o_write_clock = 1'b0;
    forever begin
      #62 o_write_clock = 1'b1;
      #63 o_write_clock = 1'b0;
    end
  end
  initial begin
    read_clock_free = 1'b0;
    #37;
    forever begin
      #62 read_clock_free = 1'b1;
      #63 read_clock_free = 1'b0;
    end
  end
  // tied mode shares the write clock; switch only with read enable high
  assign o_read_clock = i_tied ? o_write_clock : read_clock_free;
endmodule
